// ==== src/i2c_slave_defines.svh ====
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH

// Register offsets on the register port.
`define OWN_ADDR_OFF 8'h20
`define CTRL_OFF 8'h21
`define STAT_OFF 8'h22
`define DATA_OFF 8'h23
`define IRQC_OFF 8'h24

// Control register field positions.
`define CTRL_EN_BIT 7
`define CTRL_TX_BIT 4
`define CTRL_ACK_BIT 3
`define CTRL_MASK 8'h98

// Status register field positions.
`define STAT_DONE_BIT 7
`define STAT_MATCH_BIT 6
`define STAT_BUSY_BIT 5
`define STAT_DIR_BIT 2
`define STAT_RX_ACK_BIT 0

// Interrupt control register field positions.
`define IRQC_EN_BIT 0
`define IRQC_REQ_BIT 4

// Reset values.
`define CTRL_RST 8'h00
`define OWN_ADDR_RST 7'h00
`define DATA_RST 8'h00

// Bits per byte and the interrupt vector.
`define BYTE_BITS 4'h8
`define IRQ_VECTOR 8'h10

`endif

// ==== src/i2c_slave_pkg.sv ====
package i2c_slave_pkg;

    // Serial engine states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_ACK,
        ST_HOLD,
        ST_IGNORE
    } slave_state_t;

endpackage

// ==== src/i2c_slave_core.sv ====
// How it works
// - Control bit 7 enables the serial engine, not the busy flag.
// - Control bits 6-5 and 2-0 read zero.
// - Control bit 4 picks transmit or receive.
// - Control bit 3 is the ack we drive.
// - Status bit 7 sets after eight bits.
// - Address match sets status bit 6, interrupt.
// - Status bit 5 shows the bus busy.
// - Status bit 2 holds the master direction.
// - Status bit 0 records ack on ninth clock.
// - Start is SDA falling while SCL high.
// - Match: interrupt, store direction, ack low.
// - Hold SCL low until data register access.
// - Bytes are eight bits, MSB first.
// - Receiver drives programmed ack on ninth clock.
// - Transmitter releases SDA after mode switch read.
// - Data register feeds and receives the bytes.
// - Interrupt reaches core only when enabled.
// - Own address bits 7-1 hold slave address.
// - Stop clears the busy flag.
// - Control register write clears match flag.
// - Enabled interrupt branches to vector 10H.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_defines.svh"

module i2c_slave_core
    import i2c_slave_pkg::*;
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Register port.
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Core interrupt side.
    input wire logic i_stack_full,
    output logic o_irq,
    output logic [7:0] o_irq_vector,
    // Serial clock pin.
    input wire logic i_scl,
    output logic o_scl_out,
    output logic o_scl_oe_b,
    // Serial data pin.
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_b
);

    // Reset release synchroniser.
    logic rst_sync_reg;
    logic rst_b_sync_reg;
    // Pin synchronisers; the third stage feeds edge detection.
    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    // Software registers.
    logic [7:0] ctrl_reg;
    logic [6:0] own_addr_reg;
    logic [7:0] data_reg;
    logic irq_en_reg;
    logic irq_req_reg;
    // Status flags.
    logic done_reg, matched_reg, busy_reg, dir_reg, rx_ack_reg;
    // Serial engine.
    slave_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] rdata_next;

    // Release reset only after two clean clock edges.
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_reg <= 1'b0;
            rst_b_sync_reg <= 1'b0;
        end else begin
            rst_sync_reg <= 1'b1;
            rst_b_sync_reg <= rst_sync_reg;
        end
    end

    // Both pins are asynchronous to our clock, so two stages come
    // first; the third stage exists only so edges can be compared.
    always_ff @(posedge i_ref_clk or negedge rst_b_sync_reg) begin
        if (!rst_b_sync_reg) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
        end else begin
            scl_s1_reg <= i_scl;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= i_sda;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
        end
    end

    // Bus events.
    wire scl_rise = scl_s2_reg & ~scl_s3_reg;
    wire scl_fall = ~scl_s2_reg & scl_s3_reg;
    wire scl_high = scl_s2_reg & scl_s3_reg;
    wire start_evt = scl_high & sda_s3_reg & ~sda_s2_reg;
    wire stop_evt = scl_high & ~sda_s3_reg & sda_s2_reg;

    // Control fields.
    wire en = ctrl_reg[`CTRL_EN_BIT];
    wire transmit_direction_select = ctrl_reg[`CTRL_TX_BIT];
    wire ack_drive_value = ctrl_reg[`CTRL_ACK_BIT];

    // Register port decoding.
    wire wr_ctrl = i_wr & (i_addr == `CTRL_OFF);
    wire wr_own = i_wr & (i_addr == `OWN_ADDR_OFF);
    wire wr_data = i_wr & (i_addr == `DATA_OFF);
    wire rd_data = i_rd & (i_addr == `DATA_OFF);
    wire wr_irqc = i_wr & (i_addr == `IRQC_OFF);

    // Engine events derived from the state.
    wire byte_end = scl_fall & (cnt_reg == `BYTE_BITS);
    wire addr_end = (state_reg == ST_ADDR) & byte_end & ~start_evt;
    wire addr_match = shift_reg[7:1] == own_addr_reg;
    wire addr_hit = addr_end & addr_match & en;
    wire data_end = (state_reg == ST_DATA) & byte_end & ~start_evt &
        ~stop_evt & en;
    // Software touching the data register frees a held clock.
    wire release_hold = (state_reg == ST_HOLD) & (wr_data | rd_data) &
        en;
    // A write in the same cycle supplies the byte to send.
    wire [7:0] tx_byte = wr_data ? i_wdata : data_reg;

    // Read multiplexer; unmapped offsets read zero.
    wire [7:0] stat_word = {done_reg, matched_reg, busy_reg, 2'b00,
        dir_reg, 1'b0, rx_ack_reg};
    wire [7:0] irqc_word = {3'b000, irq_req_reg, 3'b000, irq_en_reg};
    assign rdata_next =
        (i_addr == `CTRL_OFF) ? (ctrl_reg & `CTRL_MASK) :
        (i_addr == `STAT_OFF) ? stat_word :
        (i_addr == `OWN_ADDR_OFF) ? {own_addr_reg, 1'b0} :
        (i_addr == `DATA_OFF) ? data_reg :
        (i_addr == `IRQC_OFF) ? irqc_word : 8'h00;

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge i_ref_clk or negedge rst_b_sync_reg) begin
        if (!rst_b_sync_reg) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rdata_next : 8'h00;
        end
    end

    // Software-owned configuration registers.
    always_ff @(posedge i_ref_clk or negedge rst_b_sync_reg) begin
        if (!rst_b_sync_reg) begin
            ctrl_reg <= `CTRL_RST;
            own_addr_reg <= `OWN_ADDR_RST;
            irq_en_reg <= 1'b0;
        end else begin
            // Only the three defined bits are stored.
            if (wr_ctrl) begin
                ctrl_reg <= i_wdata & `CTRL_MASK;
            end
            if (wr_own) begin
                own_addr_reg <= i_wdata[7:1];
            end
            if (wr_irqc) begin
                irq_en_reg <= i_wdata[`IRQC_EN_BIT];
            end
        end
    end

    // The data register is shared: software loads it for sending and
    // the engine fills it at the end of a received byte.
    always_ff @(posedge i_ref_clk or negedge rst_b_sync_reg) begin
        if (!rst_b_sync_reg) begin
            data_reg <= `DATA_RST;
        end else if (data_end & ~transmit_direction_select) begin
            data_reg <= shift_reg;
        end else if (wr_data) begin
            data_reg <= i_wdata;
        end
    end

    // Status flags; any hardware set wins over a clear in one cycle.
    always_ff @(posedge i_ref_clk or negedge rst_b_sync_reg) begin
        if (!rst_b_sync_reg) begin
            done_reg <= 1'b0;
            matched_reg <= 1'b0;
            busy_reg <= 1'b0;
            dir_reg <= 1'b0;
            rx_ack_reg <= 1'b0;
        end else begin
            // Byte flag: low while shifting, high after eight bits.
            if (addr_hit | data_end) begin
                done_reg <= 1'b1;
            end else if (release_hold | start_evt) begin
                done_reg <= 1'b0;
            end
            // A mismatching address also clears the match flag.
            if (addr_hit) begin
                matched_reg <= 1'b1;
            end else if (wr_ctrl | addr_end) begin
                matched_reg <= 1'b0;
            end
            // Busy follows start and stop even while disabled.
            if (start_evt) begin
                busy_reg <= 1'b1;
            end else if (stop_evt) begin
                busy_reg <= 1'b0;
            end
            // The eighth address bit is the master's direction.
            if (addr_hit) begin
                dir_reg <= shift_reg[0];
            end
            // Master's answer on the ninth clock of a sent byte.
            if ((state_reg == ST_ACK) & transmit_direction_select &
                ~matched_reg & scl_rise) begin
                rx_ack_reg <= sda_s2_reg;
            end
        end
    end

    // Interrupt request and its gated copy to the core.
    always_ff @(posedge i_ref_clk or negedge rst_b_sync_reg) begin
        if (!rst_b_sync_reg) begin
            irq_req_reg <= 1'b0;
            o_irq <= 1'b0;
            o_irq_vector <= 8'h00;
        end else begin
            if (addr_hit | data_end) begin
                irq_req_reg <= 1'b1;
            end else if (wr_irqc & ~i_wdata[`IRQC_REQ_BIT]) begin
                irq_req_reg <= 1'b0;
            end
            // A full call stack holds the branch off, not the flag.
            o_irq <= irq_req_reg & irq_en_reg & ~i_stack_full;
            o_irq_vector <= `IRQ_VECTOR;
        end
    end

    // Serial engine. The pins only ever pull low, so the output
    // values are fixed at zero and the enables do the work.
    always_ff @(posedge i_ref_clk or negedge rst_b_sync_reg) begin
        if (!rst_b_sync_reg) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            o_sda_oe_b <= 1'b1;
            o_scl_oe_b <= 1'b1;
            o_sda_out <= 1'b0;
            o_scl_out <= 1'b0;
        end else if (!en) begin
            // Disabled: let go of both lines at once.
            state_reg <= ST_IDLE;
            o_sda_oe_b <= 1'b1;
            o_scl_oe_b <= 1'b1;
        end else if (start_evt) begin
            // Repeated start also lands here from any state.
            state_reg <= ST_ADDR;
            cnt_reg <= 4'h0;
            o_sda_oe_b <= 1'b1;
        end else if (stop_evt) begin
            state_reg <= ST_IDLE;
            o_sda_oe_b <= 1'b1;
        end else begin
            case (state_reg)
                ST_ADDR: begin
                    // Address bits arrive MSB first on rising edges.
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s2_reg};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (addr_end & addr_match) begin
                        state_reg <= ST_ACK;
                        o_sda_oe_b <= 1'b0;
                    end else if (addr_end) begin
                        state_reg <= ST_IGNORE;
                    end
                end
                ST_HOLD: begin
                    // SCL stays low until software reaches the data.
                    if (release_hold) begin
                        state_reg <= ST_DATA;
                        cnt_reg <= 4'h0;
                        o_scl_oe_b <= 1'b1;
                        shift_reg <= tx_byte;
                        // Receive mode keeps SDA released.
                        o_sda_oe_b <= transmit_direction_select ?
                            tx_byte[7] : 1'b1;
                    end
                end
                ST_DATA: begin
                    if (scl_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (!transmit_direction_select) begin
                            shift_reg <= {shift_reg[6:0], sda_s2_reg};
                        end
                    end else if (byte_end) begin
                        state_reg <= ST_ACK;
                        // Receiver answers with the programmed value.
                        o_sda_oe_b <= transmit_direction_select ? 1'b1 :
                            ack_drive_value;
                    end else if (scl_fall & transmit_direction_select) begin
                        // Next bit goes out while SCL is low.
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        o_sda_oe_b <= shift_reg[6];
                    end
                end
                ST_ACK: begin
                    // End of the ninth clock: let go and stretch.
                    if (scl_fall) begin
                        state_reg <= ST_HOLD;
                        o_sda_oe_b <= 1'b1;
                        o_scl_oe_b <= 1'b0;
                    end
                end
                default: begin
                    // Idle or not addressed: wait for a start.
                    o_sda_oe_b <= 1'b1;
                    o_scl_oe_b <= 1'b1;
                end
            endcase
        end
    end

    // Checks on the engine and the flags.
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_b_sync_reg);

    property p_busy_set;
        start_evt |=> busy_reg;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy flag not set by start");

    property p_busy_clear;
        stop_evt && !start_evt |=> !busy_reg ##1 !busy_reg || start_evt;
    endproperty
    a_busy_clear: assert property (p_busy_clear)
        else $error("busy flag not cleared by stop");

    property p_ctrl_reserved;
        i_rd && i_addr == `CTRL_OFF |=> (o_rdata & ~`CTRL_MASK) == 8'h00;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("reserved control bits read nonzero");

    property p_disabled_quiet;
        !en |=> o_sda_oe_b && o_scl_oe_b;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled slave drives a line");

    property p_match_flags;
        addr_hit |=> matched_reg && irq_req_reg && !o_sda_oe_b &&
            dir_reg == $past(shift_reg[0]);
    endproperty
    a_match_flags: assert property (p_match_flags)
        else $error("address match effects missing");

    property p_ctrl_clears_match;
        wr_ctrl && !addr_hit |=> !matched_reg;
    endproperty
    a_ctrl_clears_match: assert property (p_ctrl_clears_match)
        else $error("control write left match flag set");

    property p_hold_low;
        state_reg == ST_HOLD && !release_hold && en && !start_evt
            |=> !o_scl_oe_b;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("clock released without data access");

    property p_done_set;
        data_end |=> done_reg && state_reg == ST_ACK;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("byte flag not set after eight bits");

    property p_irq_gate;
        o_irq |-> $past(irq_en_reg) && $past(irq_req_reg);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");

endmodule
`default_nettype wire

// ==== test/i2c_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behavioural two-wire bus master; 1 in a drive output releases the wire.
module i2c_master_model (
    // Wire levels seen on the bus.
    input wire logic i_scl,
    input wire logic i_sda,
    // Open-drain drives, 0 pulls the wire low.
    output logic o_scl_drv,
    output logic o_sda_drv
);
    // Both wires released at time zero, so the bus idles high.
    initial begin
        o_scl_drv = 1'b1;
        o_sda_drv = 1'b1;
    end

    // Release the clock and wait while the slave stretches it.
    // The wait is bounded so a stuck stretch ends in the bench timeout.
    task automatic scl_up;
        int n;
        o_scl_drv = 1'b1;
        for (n = 0; n < 4000 && i_scl !== 1'b1; n++) begin
            #100;
        end
    endtask

    // Data falls while the clock is high.
    task automatic start;
        o_sda_drv = 1'b0;
        #400;
        o_scl_drv = 1'b0;
        #400;
    endtask

    // Data rises while the clock is high, which frees the bus.
    task automatic stop;
        o_sda_drv = 1'b0;
        #200;
        scl_up();
        #400;
        o_sda_drv = 1'b1;
        #400;
    endtask

    // One clock: data set early in the low phase, sampled late in high.
    // Late sampling leaves room for the slave's synchroniser delay.
    task automatic bit_x(input logic b, output logic s);
        #100;
        o_sda_drv = b;
        #300;
        scl_up();
        #380;
        s = i_sda;
        #20;
        o_scl_drv = 1'b0;
    endtask

    // Eight bits MSB first, then the ninth clock with bit a.
    task automatic xbyte(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic k);
        int i;
        logic s;
        for (i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
            q[i] = s;
        end
        bit_x(a, k);
    endtask
endmodule

`default_nettype wire

// ==== test/test_i2c_slave_interface.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_defines.svh"

module test_i2c_slave_interface;
    logic clk, rst_b, wr, rd, stack_full, irq;
    logic [7:0] addr, wdata, rdata, vec, q, d1, d2;
    logic scl_out, scl_oe_b, sda_out, sda_oe_b, m_scl, m_sda, k;
    logic [6:0] own;
    int seed = 70;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // Open-drain wires with pull-ups: low if any party pulls.
    wire scl = (scl_oe_b | scl_out) & m_scl;
    wire sda = (sda_oe_b | sda_out) & m_sda;

    i2c_slave_core DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_stack_full(stack_full), .o_irq(irq), .o_irq_vector(vec),
        .i_scl(scl), .o_scl_out(scl_out), .o_scl_oe_b(scl_oe_b),
        .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_b(sda_oe_b));

    i2c_master_model M (.i_scl(scl), .i_sda(sda), .o_scl_drv(m_scl),
        .o_sda_drv(m_sda));

    // Clock at 10 MHz.
    always #50 clk = ~clk;

    // A hang anywhere is cut short well past the expected run length.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Status word built from {done, matched, busy, direction, no-ack}.
    function automatic logic [7:0] exp_stat(input logic [4:0] f);
        logic [7:0] w;
        w = 8'h00;
        w[`STAT_DONE_BIT] = f[4];
        w[`STAT_MATCH_BIT] = f[3];
        w[`STAT_BUSY_BIT] = f[2];
        w[`STAT_DIR_BIT] = f[1];
        w[`STAT_RX_ACK_BIT] = f[0];
        return w;
    endfunction

    // One-cycle write strobe, then one idle edge before the next access.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk($sformatf("reg %h", a), d & m, e);
    endtask

    // Wait for the slave to stretch the clock and see that it keeps it.
    task automatic hold;
        int n;
        for (n = 0; n < 200 && scl_oe_b !== 1'b0; n++) begin
            @(posedge clk);
        end
        repeat (20) @(posedge clk);
        chk("stretch", {7'h0, scl_oe_b}, 8'h00);
    endtask

    initial begin
        logic [7:0] offs [6] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
        clk = 1'b0;
        rst_b = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        stack_full = 1'b0;
        own = 7'($random(seed));
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        // The vector register loads on the third edge; look one later.
        repeat (4) @(posedge clk);
        chk("vector", vec, 8'h10);
        // Every register, and one unmapped place, reads zero after reset.
        foreach (offs[i]) rd_chk(offs[i], 8'hff, 8'h00);
        wr_reg(`CTRL_OFF, 8'hff);
        rd_chk(`CTRL_OFF, 8'hff, 8'h98);
        wr_reg(`OWN_ADDR_OFF, {own, 1'b1});
        rd_chk(`OWN_ADDR_OFF, 8'hff, {own, 1'b0});
        wr_reg(`IRQC_OFF, 8'h01);
        // Disabled slave must not answer its own address.
        wr_reg(`CTRL_OFF, 8'h00);
        M.start();
        M.xbyte({own, 1'b0}, 1'b1, q, k);
        chk("ack off", {7'h0, k}, 8'h01);
        M.stop();
        // A foreign address is ignored.
        wr_reg(`CTRL_OFF, 8'h80);
        M.start();
        M.xbyte({own ^ 7'h01, 1'b0}, 1'b1, q, k);
        chk("ack other", {7'h0, k}, 8'h01);
        rd_chk(`STAT_OFF, 8'h40, 8'h00);
        M.stop();
        // Master writes two bytes; the second is refused by software.
        M.start();
        repeat (10) @(posedge clk);
        rd_chk(`STAT_OFF, 8'h20, 8'h20);
        M.xbyte({own, 1'b0}, 1'b1, q, k);
        chk("addr ack", {7'h0, k}, 8'h00);
        rd_chk(`STAT_OFF, 8'he4, exp_stat(5'b11100));
        chk("irq", {7'h0, irq}, 8'h01);
        @(posedge clk);
        stack_full <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq full", {7'h0, irq}, 8'h00);
        stack_full <= 1'b0;
        wr_reg(`IRQC_OFF, 8'h10);
        repeat (2) @(posedge clk);
        chk("irq masked", {7'h0, irq}, 8'h00);
        // Writing 1 to the request bit keeps the pending request.
        rd_chk(`IRQC_OFF, 8'h11, 8'h10);
        wr_reg(`IRQC_OFF, 8'h01);
        // Writing 0 to the request bit clears it.
        rd_chk(`IRQC_OFF, 8'h11, 8'h01);
        hold();
        rd_reg(`DATA_OFF, q);
        M.xbyte(d1, 1'b1, q, k);
        chk("data ack", {7'h0, k}, 8'h00);
        hold();
        rd_chk(`STAT_OFF, 8'ha4, exp_stat(5'b10100));
        wr_reg(`CTRL_OFF, 8'h88);
        rd_chk(`DATA_OFF, 8'hff, d1);
        M.xbyte(d2, 1'b1, q, k);
        chk("data nack", {7'h0, k}, 8'h01);
        hold();
        rd_chk(`DATA_OFF, 8'hff, d2);
        M.stop();
        repeat (10) @(posedge clk);
        rd_chk(`STAT_OFF, 8'h20, 8'h00);
        // Master reads two bytes and refuses the second.
        wr_reg(`CTRL_OFF, 8'h80);
        M.start();
        M.xbyte({own, 1'b1}, 1'b1, q, k);
        chk("rd addr ack", {7'h0, k}, 8'h00);
        hold();
        rd_chk(`STAT_OFF, 8'h04, 8'h04);
        wr_reg(`CTRL_OFF, 8'h90);
        rd_chk(`STAT_OFF, 8'h40, 8'h00);
        wr_reg(`DATA_OFF, d1);
        M.xbyte(8'hff, 1'b0, q, k);
        chk("tx byte", q, d1);
        hold();
        rd_chk(`STAT_OFF, 8'h81, 8'h80);
        wr_reg(`DATA_OFF, d2);
        M.xbyte(8'hff, 1'b1, q, k);
        chk("tx byte2", q, d2);
        hold();
        rd_chk(`STAT_OFF, 8'h01, 8'h01);
        wr_reg(`CTRL_OFF, 8'h80);
        rd_reg(`DATA_OFF, q);
        repeat (2) @(posedge clk);
        chk("sda free", {7'h0, sda_oe_b}, 8'h01);
        M.stop();
        wrap_up();
    end
endmodule

`default_nettype wire
